// ---- nfc_ctrl.sv ----
`timescale 1ns/10ps
module nfc_ctrl #(
    parameter int unsigned PWR_WAIT_CYC = nfc_pkg::PWR_WAIT_CYC
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  nfc_pkg::nfc_req_s      req,
    input  wire logic              wdata_valid,
    input  wire logic [7:0]        wdata,
    output logic                   wdata_ready,
    output logic                   rdata_valid,
    output logic [7:0]             rdata,
    output logic                   done,
    output logic [7:0]             status,
    output logic                   pass_fail_valid,
    output logic                   fail,
    input  wire logic              protect_en,
    output nfc_pkg::nfc_pins_s     pins,
    output logic                   ce_n,
    output logic                   wp_n,
    input  wire logic [7:0]        io_in,
    input  wire logic              ready_busy_n
);

    typedef enum logic [3:0] {
        ST_POWER  = 4'b0000,
        ST_IDLE   = 4'b0001,
        ST_CMD1   = 4'b0011,
        ST_ADDR   = 4'b0010,
        ST_WDATA  = 4'b0110,
        ST_CMD2   = 4'b0111,
        ST_SETTLE = 4'b0101,
        ST_BUSY   = 4'b0100,
        ST_RDATA  = 4'b1100
    } nfc_state_e;

    nfc_state_e                    state_q;
    nfc_pkg::nfc_op_e              op_q;
    logic [7:0]                    col_q;
    logic [15:0]                   page_q;
    logic [nfc_pkg::CNT_W-1:0]     cnt_q;
    logic [1:0]                    aidx_q;
    logic                          stat_pend_q;
    logic [nfc_pkg::PWR_W-1:0]     pwr_q;
    logic [nfc_pkg::SET_W-1:0]     settle_q;
    logic                          rb_meta_q;
    logic                          rb_sync_q;
    logic [7:0]                    rdata_q;
    logic                          rdata_valid_q;
    logic                          done_q;
    logic [7:0]                    status_q;
    logic                          ce_n_q;
    logic                          wp_n_q;

    logic                          eng_ready;
    logic                          eng_done;
    logic [7:0]                    eng_rbyte;

    wire is_read   = (op_q == nfc_pkg::OP_READ_A) || (op_q == nfc_pkg::OP_READ_B)
                     || (op_q == nfc_pkg::OP_READ_C);
    wire is_pe     = (op_q == nfc_pkg::OP_PROGRAM) || (op_q == nfc_pkg::OP_ERASE);
    wire last_byte = (cnt_q <= nfc_pkg::CNT_W'(1));
    wire xfer_st   = (state_q == ST_CMD1) || (state_q == ST_ADDR) || (state_q == ST_WDATA)
                     || (state_q == ST_CMD2) || (state_q == ST_RDATA);
    wire eng_free  = eng_ready && !eng_done;
    wire eng_start = xfer_st && eng_free && ((state_q != ST_WDATA) || wdata_valid);
    wire pwr_end   = (pwr_q == nfc_pkg::PWR_W'(PWR_WAIT_CYC - 1));

    wire [7:0] cmd1_w =
        (op_q == nfc_pkg::OP_READ_A)  ? nfc_pkg::CMD_READ_A    :
        (op_q == nfc_pkg::OP_READ_B)  ? nfc_pkg::CMD_READ_B    :
        (op_q == nfc_pkg::OP_READ_C)  ? nfc_pkg::CMD_READ_C    :
        (op_q == nfc_pkg::OP_STATUS)  ? nfc_pkg::CMD_STATUS    :
        (op_q == nfc_pkg::OP_PROGRAM) ? nfc_pkg::CMD_DATA_IN   :
        (op_q == nfc_pkg::OP_ERASE)   ? nfc_pkg::CMD_ERASE_SET :
        (op_q == nfc_pkg::OP_ID)      ? nfc_pkg::CMD_ID        : nfc_pkg::CMD_RESET;
    wire [7:0] cmd2_w =
        stat_pend_q                   ? nfc_pkg::CMD_STATUS    :
        (op_q == nfc_pkg::OP_PROGRAM) ? nfc_pkg::CMD_PROG_EXEC : nfc_pkg::CMD_ERASE_GO;
    wire [7:0] addr_w =
        (aidx_q == nfc_pkg::AIDX_COL) ? col_q :
        (aidx_q == nfc_pkg::AIDX_PLO) ? page_q[7:0] : page_q[15:8];
    wire [1:0] addr_last = (op_q == nfc_pkg::OP_ID) ? nfc_pkg::AIDX_COL : nfc_pkg::AIDX_PHI;
    wire [1:0] addr_first = (req.op == nfc_pkg::OP_ERASE) ? nfc_pkg::AIDX_PLO
                                                          : nfc_pkg::AIDX_COL;

    wire [7:0] eng_byte =
        (state_q == ST_CMD1)  ? cmd1_w :
        (state_q == ST_CMD2)  ? cmd2_w :
        (state_q == ST_ADDR)  ? addr_w : wdata;
    wire nfc_pkg::nfc_cyc_e eng_kind =
        (state_q == ST_ADDR)  ? nfc_pkg::CY_ADDR  :
        (state_q == ST_WDATA) ? nfc_pkg::CY_WDATA :
        (state_q == ST_RDATA) ? nfc_pkg::CY_RDATA : nfc_pkg::CY_CMD;

    assign req_ready       = (state_q == ST_IDLE);
    assign wdata_ready     = (state_q == ST_WDATA) && eng_free;
    assign rdata           = rdata_q;
    assign rdata_valid     = rdata_valid_q;
    assign done            = done_q;
    assign status          = status_q;
    assign ce_n            = ce_n_q;
    assign wp_n            = wp_n_q;
    assign pass_fail_valid = status_q[nfc_pkg::STAT_READY_BIT];
    assign fail            = status_q[nfc_pkg::STAT_FAIL_BIT] && pass_fail_valid;

    nfc_cycle nfc_cycle_inst (
        .clock    (clock),
        .reset_n  (reset_n),
        .start    (eng_start),
        .kind     (eng_kind),
        .byte_out (eng_byte),
        .io_in    (io_in),
        .ready    (eng_ready),
        .done     (eng_done),
        .rbyte    (eng_rbyte),
        .pins     (pins)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rb_meta_q <= 1'b0;
            rb_sync_q <= 1'b0;
            wp_n_q    <= 1'b0;
        end else begin
            rb_meta_q <= ready_busy_n;
            rb_sync_q <= rb_meta_q;
            wp_n_q    <= !protect_en && (state_q != ST_POWER);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q       <= ST_POWER;
            op_q          <= nfc_pkg::OP_RESET;
            col_q         <= nfc_pkg::BYTE_RST;
            page_q        <= '0;
            cnt_q         <= '0;
            aidx_q        <= nfc_pkg::AIDX_COL;
            stat_pend_q   <= 1'b0;
            pwr_q         <= '0;
            settle_q      <= '0;
            rdata_q       <= nfc_pkg::BYTE_RST;
            rdata_valid_q <= 1'b0;
            done_q        <= 1'b0;
            status_q      <= nfc_pkg::BYTE_RST;
            ce_n_q        <= 1'b1;
        end else begin
            rdata_valid_q <= 1'b0;
            done_q        <= 1'b0;
            unique case (state_q)
                ST_POWER: begin
                    pwr_q <= pwr_q + 1'b1;
                    if (pwr_end) state_q <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (req_valid) begin
                        op_q        <= req.op;
                        col_q       <= (req.op == nfc_pkg::OP_ID) ? nfc_pkg::BYTE_RST
                                                                  : req.column;
                        page_q      <= req.page;
                        cnt_q       <= (req.op == nfc_pkg::OP_STATUS) ? nfc_pkg::CNT_W'(1) :
                                       (req.op == nfc_pkg::OP_ID)     ? nfc_pkg::CNT_W'(2) :
                                       req.count;
                        aidx_q      <= addr_first;
                        stat_pend_q <= 1'b0;
                        ce_n_q      <= 1'b0;
                        state_q     <= ST_CMD1;
                    end
                end
                ST_CMD1: begin
                    if (eng_done) begin
                        state_q <= (op_q == nfc_pkg::OP_STATUS) ? ST_RDATA  :
                                   (op_q == nfc_pkg::OP_RESET)  ? ST_SETTLE : ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (eng_done) begin
                        aidx_q <= aidx_q + 1'b1;
                        if (aidx_q == addr_last) begin
                            state_q <= (op_q == nfc_pkg::OP_PROGRAM) ? ST_WDATA :
                                       (op_q == nfc_pkg::OP_ERASE)   ? ST_CMD2  :
                                       (op_q == nfc_pkg::OP_ID)      ? ST_RDATA : ST_SETTLE;
                        end
                    end
                end
                ST_WDATA: begin
                    if (eng_done) begin
                        cnt_q <= cnt_q - 1'b1;
                        if (last_byte) state_q <= ST_CMD2;
                    end
                end
                ST_CMD2: begin
                    if (eng_done) state_q <= stat_pend_q ? ST_RDATA : ST_SETTLE;
                end
                ST_SETTLE: begin
                    settle_q <= settle_q + 1'b1;
                    if (settle_q == nfc_pkg::SET_W'(nfc_pkg::SETTLE_CYC - 1)) begin
                        settle_q <= '0;
                        state_q  <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (rb_sync_q) begin
                        if (is_pe) begin
                            stat_pend_q <= 1'b1;
                            cnt_q       <= nfc_pkg::CNT_W'(1);
                            state_q     <= ST_CMD2;
                        end else if (is_read) begin
                            state_q <= ST_RDATA;
                        end else begin
                            ce_n_q  <= 1'b1;
                            done_q  <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_RDATA: begin
                    if (eng_done) begin
                        cnt_q <= cnt_q - 1'b1;
                        if (stat_pend_q || (op_q == nfc_pkg::OP_STATUS)) begin
                            status_q <= eng_rbyte;
                        end
                        if (!stat_pend_q) begin
                            rdata_q       <= eng_rbyte;
                            rdata_valid_q <= 1'b1;
                        end
                        if (last_byte) begin
                            ce_n_q  <= 1'b1;
                            done_q  <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // nfc_ctrl

// ---- nfc_ctrl_asserts.sv ----
`timescale 1ns/10ps
module nfc_ctrl_asserts #(
    parameter int unsigned PWR_WAIT_CYC = 20
) (
    input wire logic          clock,
    input wire logic          reset_n,
    input wire logic          req_valid,
    input wire logic          req_ready,
    input wire logic          rdata_valid,
    input wire logic          done,
    input wire logic [7:0]    status,
    input wire logic          pass_fail_valid,
    input wire logic          fail,
    input nfc_pkg::nfc_pins_s pins,
    input wire logic          ce_n,
    input wire logic          ready_busy_n
);
    int unsigned pc_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) pc_q <= 0;
        else if (pc_q < PWR_WAIT_CYC) pc_q <= pc_q + 1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    power_wait_a: assert property (req_ready |-> pc_q == PWR_WAIT_CYC)
        else $error("request accepted during power wait");
    take_select_a: assert property (req_valid && req_ready |=> !req_ready && !ce_n)
        else $error("request not taken cleanly");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    byte_pulse_a: assert property (rdata_valid |=> !rdata_valid)
        else $error("read byte pulse too long");
    latch_drive_a: assert property (!pins.we_n |-> pins.io_oe && pins.read_strobe_n
        && !(pins.cle && pins.ale)) else $error("bad write cycle pins");
    cmd_legal_a: assert property (pins.cle && !pins.we_n |-> pins.io_out inside
        {8'h00, 8'h01, 8'h50, 8'h70, 8'h80, 8'h10, 8'h60, 8'hD0, 8'hFF, 8'h90})
        else $error("undefined command code");
    busy_cmd_a: assert property (pins.cle && !pins.we_n && !ready_busy_n |->
        pins.io_out inside {8'h70, 8'hFF}) else $error("command while busy");
    busy_select_a: assert property ((!ready_busy_n) [*3] |-> !ce_n)
        else $error("chip select released while busy");
    // fail may only appear once the device itself reports ready
    fail_valid_a: assert property ($rose(fail) |-> ready_busy_n && status[6])
        else $error("fail raised without ready device");
    cover property (done && status[6]);
    cover property (rdata_valid);
    cover property (fail);
endmodule // nfc_ctrl_asserts

bind nfc_ctrl nfc_ctrl_asserts #(.PWR_WAIT_CYC(PWR_WAIT_CYC)) nfc_ctrl_asserts_inst (
    .clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
    .rdata_valid(rdata_valid), .done(done), .status(status),
    .pass_fail_valid(pass_fail_valid), .fail(fail), .pins(pins), .ce_n(ce_n),
    .ready_busy_n(ready_busy_n));

// ---- nfc_ctrl_test.sv ----
`timescale 1ns/10ps
module nfc_ctrl_test;
    logic               clock = 0, reset_n = 0, req_valid = 0, wdata_valid = 0;
    logic               protect_en = 0, fail_prog = 0;
    nfc_pkg::nfc_req_s  req = '0;
    nfc_pkg::nfc_pins_s pins;
    logic [7:0]         rdata, status, io_in;
    logic [7:0]         wbuf [0:3] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic               req_ready, wdata_ready, rdata_valid, done, pass_fail_valid, fail;
    logic               ce_n, wp_n, ready_busy_n;
    int unsigned        err_total = 0, samples_checked = 0, wi = 0;
    logic [7:0]         got [$];
    always #2 clock = ~clock;
    always @(posedge clock) if (wdata_valid && wdata_ready) wi <= wi + 1;
    nfc_ctrl #(.PWR_WAIT_CYC(20)) nfc_ctrl_inst (.clock(clock), .reset_n(reset_n),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .wdata_valid(wdata_valid),
        .wdata(wbuf[wi]), .wdata_ready(wdata_ready), .rdata_valid(rdata_valid), .rdata(rdata),
        .done(done), .status(status), .pass_fail_valid(pass_fail_valid), .fail(fail),
        .protect_en(protect_en), .pins(pins), .ce_n(ce_n), .wp_n(wp_n), .io_in(io_in),
        .ready_busy_n(ready_busy_n));
    nfc_flash_model nfc_flash_model_inst (.ce_n(ce_n), .wp_n(wp_n), .fail_prog(fail_prog),
        .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] init_byte(input int a);
        return a[7:0] ^ 8'h5A;
    endfunction
    // one request, collecting read bytes until done
    task automatic run(input nfc_pkg::nfc_op_e op, input logic [7:0] col, input int cnt);
        int n;
        got.delete();
        req <= '{op: op, column: col, page: 16'h0123, count: 10'(cnt)};
        req_valid <= 1'b1;
        wdata_valid <= (op == nfc_pkg::OP_PROGRAM);
        wi <= 0;
        n = 0;
        do @(posedge clock); while (!req_ready && ++n < 100);
        req_valid <= 1'b0;
        n = 0;
        while (!done && n < 4000) begin
            @(posedge clock);
            n++;
            if (rdata_valid) got.push_back(rdata);
        end
        wdata_valid <= 1'b0;
        check({7'h00, done}, 8'h01);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        repeat (5) @(posedge clock);
        check({7'h00, req_ready}, 8'h00);
        run(nfc_pkg::OP_ID, 8'h00, 2);
        check(8'(got.size()), 8'h02);
        check(got[0], 8'hA5);
        check(got[1], 8'h3C);
        run(nfc_pkg::OP_STATUS, 8'h00, 1);
        check(got[0], 8'hC0);
        run(nfc_pkg::OP_READ_A, 8'h05, 3);
        for (int k = 0; k < 3; k++) check(got[k], init_byte(5 + k));
        run(nfc_pkg::OP_READ_B, 8'h02, 2);
        for (int k = 0; k < 2; k++) check(got[k], init_byte(258 + k));
        run(nfc_pkg::OP_READ_C, 8'h0E, 4);
        for (int k = 0; k < 4; k++) check(got[k], init_byte(k < 2 ? 526 + k : 527));
        run(nfc_pkg::OP_PROGRAM, 8'h08, 3);
        check(8'(wi), 8'h03);
        check(status, 8'hC0);
        check({7'h00, pass_fail_valid}, 8'h01);
        check({7'h00, fail}, 8'h00);
        run(nfc_pkg::OP_READ_A, 8'h08, 3);
        for (int k = 0; k < 3; k++) check(got[k], wbuf[k]);
        fail_prog <= 1'b1;
        run(nfc_pkg::OP_PROGRAM, 8'h08, 1);
        check(status, 8'hC1);
        check({7'h00, fail}, 8'h01);
        fail_prog <= 1'b0;
        run(nfc_pkg::OP_ERASE, 8'h00, 1);
        check(status, 8'hC0);
        run(nfc_pkg::OP_READ_A, 8'h00, 2);
        for (int k = 0; k < 2; k++) check(got[k], 8'hFF);
        run(nfc_pkg::OP_RESET, 8'h00, 1);
        run(nfc_pkg::OP_READ_A, 8'h09, 1);
        check(got[0], 8'hFF);
        protect_en <= 1'b1;
        run(nfc_pkg::OP_STATUS, 8'h00, 1);
        check(got[0], 8'h40);
        wrap_up;
    end
    initial begin
        #200000;
        err_total++;
        wrap_up;
    end
endmodule // nfc_ctrl_test

// ---- nfc_cycle.sv ----
`timescale 1ns/10ps
module nfc_cycle (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              start,
    input  nfc_pkg::nfc_cyc_e      kind,
    input  wire logic [7:0]        byte_out,
    input  wire logic [7:0]        io_in,
    output logic                   ready,
    output logic                   done,
    output logic [7:0]             rbyte,
    output nfc_pkg::nfc_pins_s     pins
);

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LOW  = 2'b01,
        PH_HIGH = 2'b11
    } nfc_phase_e;

    nfc_phase_e                    ph_q;
    logic [nfc_pkg::DIV_W-1:0]     div_q;
    logic [7:0]                    io_meta_q;
    logic [7:0]                    io_sync_q;
    logic                          done_q;
    logic [7:0]                    rbyte_q;
    nfc_pkg::nfc_pins_s            pins_q;

    // divider enable: one pulse per strobe phase
    wire tick = (div_q == nfc_pkg::DIV_W'(nfc_pkg::STROBE_CYC - 1));
    wire is_rd = (kind == nfc_pkg::CY_RDATA);

    assign ready = (ph_q == PH_IDLE);
    assign done  = done_q;
    assign rbyte = rbyte_q;
    assign pins  = pins_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            io_meta_q <= nfc_pkg::BYTE_RST;
            io_sync_q <= nfc_pkg::BYTE_RST;
        end else begin
            io_meta_q <= io_in;
            io_sync_q <= io_meta_q;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ph_q    <= PH_IDLE;
            div_q   <= '0;
            done_q  <= 1'b0;
            rbyte_q <= nfc_pkg::BYTE_RST;
            pins_q  <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
                         io_out: nfc_pkg::BYTE_RST, io_oe: 1'b0};
        end else begin
            done_q <= 1'b0;
            div_q  <= tick ? '0 : div_q + 1'b1;
            unique case (ph_q)
                PH_IDLE: begin
                    if (start) begin
                        ph_q                 <= PH_LOW;
                        div_q                <= '0;
                        pins_q.cle           <= (kind == nfc_pkg::CY_CMD);
                        pins_q.ale           <= (kind == nfc_pkg::CY_ADDR);
                        pins_q.io_out        <= byte_out;
                        pins_q.io_oe         <= !is_rd;
                        pins_q.we_n          <= is_rd;
                        pins_q.read_strobe_n <= !is_rd;
                    end
                end
                PH_LOW: begin
                    if (tick) begin
                        ph_q                 <= PH_HIGH;
                        pins_q.we_n          <= 1'b1;
                        pins_q.read_strobe_n <= 1'b1;
                        // sample late in the low phase, data path is two flops deep
                        rbyte_q              <= io_sync_q;
                    end
                end
                PH_HIGH: begin
                    if (tick) begin
                        ph_q         <= PH_IDLE;
                        done_q       <= 1'b1;
                        pins_q.cle   <= 1'b0;
                        pins_q.ale   <= 1'b0;
                        pins_q.io_oe <= 1'b0;
                    end
                end
                default: ph_q <= PH_IDLE;
            endcase
        end
    end

endmodule // nfc_cycle

// ---- nfc_flash_model.sv ----
`timescale 1ns/10ps
module nfc_flash_model #(
    parameter logic [7:0] MAKER_CODE  = 8'hA5, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3C, // arbitrary value
    parameter int         BUSY_NS     = 400
) (
    input wire logic          ce_n,
    input wire logic          wp_n,
    input wire logic          fail_prog,
    input nfc_pkg::nfc_pins_s pins,
    output logic [7:0]        io_in,
    output logic              ready_busy_n = 1'b1
);
    logic [7:0] mem [0:527];
    logic [7:0] cmd = 8'h00, pcmd, dout = 8'h00;
    logic [9:0] ptr = 10'h000;
    logic       drv = 1'b0, pfail = 1'b0;
    int         acnt = 0;
    wire  [7:0] din = pins.io_out;
    // released bus shows the inverse of the last byte
    assign io_in = drv ? dout : ~dout;
    initial for (int i = 0; i < 528; i++) mem[i] = 8'(i) ^ 8'h5A;
    task automatic go_busy(input int ns);
        ready_busy_n = 1'b0;
        ready_busy_n <= #(ns) 1'b1;
    endtask
    always @(posedge pins.we_n) begin
        if (!ce_n && pins.cle) begin
            pcmd = cmd;
            cmd = din;
            acnt = 0;
            case (din)
                8'h00, 8'h80, 8'h90: ptr = 10'h000;
                8'h01: ptr = 10'h100;
                8'h50: ptr = 10'h200;
                8'h10: begin
                    pfail = fail_prog | !wp_n;
                    go_busy(2 * BUSY_NS);
                end
                8'hD0: if (pcmd == 8'h60) begin
                    if (wp_n) for (int i = 0; i < 528; i++) mem[i] = 8'hFF;
                    pfail = fail_prog;
                    go_busy(2 * BUSY_NS);
                end
                8'hFF: go_busy(50);
                default: ;
            endcase
        // column first, transfer after third address
        end else if (!ce_n && pins.ale) begin
            acnt++;
            if (acnt == 1) ptr = ptr + ((cmd == 8'h50) ? {6'h00, din[3:0]} : {2'h0, din});
            if (acnt == 3 && cmd inside {8'h00, 8'h01, 8'h50}) go_busy(BUSY_NS);
        end else if (!ce_n && cmd == 8'h80) begin
            if (wp_n) mem[ptr] = din;
            ptr++;
        end
    end
    always @(negedge pins.read_strobe_n) begin
        if (!ce_n) begin
            drv = 1'b1;
            if (cmd == 8'h70) dout = {wp_n, ready_busy_n, 5'h00, pfail};
            else if (cmd == 8'h90) dout = (ptr == 10'h000) ? MAKER_CODE : DEVICE_CODE;
            else dout = mem[ptr];
            if (ptr < 10'd527) ptr++;
        end
    end
    always @(posedge pins.read_strobe_n) drv = 1'b0;
endmodule // nfc_flash_model

// ---- nfc_pkg.sv ----
package nfc_pkg;

    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned STROBE_NS    = 25;
    localparam int unsigned STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETTLE_NS    = 100;
    localparam int unsigned SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PWR_WAIT_US  = 200;
    localparam int unsigned PWR_WAIT_CYC = PWR_WAIT_US * CLK_MHZ;

    localparam logic [7:0] CMD_READ_A    = 8'h00;
    localparam logic [7:0] CMD_READ_B    = 8'h01;
    localparam logic [7:0] CMD_READ_C    = 8'h50;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_DATA_IN   = 8'h80;
    localparam logic [7:0] CMD_PROG_EXEC = 8'h10;
    localparam logic [7:0] CMD_ERASE_SET = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
    localparam logic [7:0] CMD_RESET     = 8'hFF;
    localparam logic [7:0] CMD_ID        = 8'h90;

    localparam int unsigned STAT_FAIL_BIT  = 0;
    localparam int unsigned STAT_READY_BIT = 6;
    localparam int unsigned STAT_WP_BIT    = 7;

    localparam int unsigned CNT_W   = 10;
    localparam int unsigned PWR_W   = 17;
    localparam int unsigned SET_W   = 6;
    localparam int unsigned DIV_W   = 4;
    localparam logic [7:0]  BYTE_RST = 8'h00;
    localparam logic [1:0]  AIDX_COL  = 2'h0;
    localparam logic [1:0]  AIDX_PLO  = 2'h1;
    localparam logic [1:0]  AIDX_PHI  = 2'h2;

    typedef enum logic [2:0] {
        OP_READ_A  = 3'h0,
        OP_READ_B  = 3'h1,
        OP_READ_C  = 3'h2,
        OP_STATUS  = 3'h3,
        OP_PROGRAM = 3'h4,
        OP_ERASE   = 3'h5,
        OP_RESET   = 3'h6,
        OP_ID      = 3'h7
    } nfc_op_e;

    typedef enum logic [1:0] {
        CY_CMD   = 2'h0,
        CY_ADDR  = 2'h1,
        CY_WDATA = 2'h2,
        CY_RDATA = 2'h3
    } nfc_cyc_e;

    typedef struct packed {
        nfc_op_e           op;
        logic [7:0]        column;
        logic [15:0]       page;
        logic [CNT_W-1:0]  count;
    } nfc_req_s;

    typedef struct packed {
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       read_strobe_n;
        logic [7:0] io_out;
        logic       io_oe;
    } nfc_pins_s;

endpackage
